// *** atap_defines.svh ***
// register offsets, field positions, reset values and widths of the trim block
`ifndef ATAP_DEFINES_SVH
`define ATAP_DEFINES_SVH
// ========================================
// register byte offsets, word indices of the two trim stores and store depth
`define ATAP_OFS_CTRL3      8'h00
`define ATAP_OFS_OFS_HI     8'h04
`define ATAP_OFS_OFS_LO     8'h08
`define ATAP_OFS_PG_HI      8'h0C
`define ATAP_OFS_PG_LO      8'h10
`define ATAP_OFS_MG_HI      8'h14
`define ATAP_OFS_MG_LO      8'h18
`define ATAP_OFS_PIN_LO     8'h1C
`define ATAP_OFS_PIN_MID    8'h20
`define ATAP_OFS_CTRL2      8'h24
`define ATAP_OFS_CHAN1      8'h28
`define ATAP_OFS_RESULT     8'h2C
`define ATAP_IDX_PSTORE     6'h0C
`define ATAP_IDX_MSTORE     6'h14
`define ATAP_STORE_N        7
// ========================================
// field positions
`define ATAP_B_RUN          7
`define ATAP_B_FAIL         6
`define ATAP_B_REPEAT       3
`define ATAP_B_AVGEN        2
`define ATAP_B_HWTRG        6
`define ATAP_B_DIFF         0
`define ATAP_B_BUSY         16
// ========================================
// reset values and responses
`define ATAP_RST_GAIN       16'h8000
`define ATAP_RST_OFS        16'h0000
`define ATAP_RST_BYTE       8'h00
`define ATAP_RESP_OK        2'h0
`define ATAP_RESP_ERR       2'h2
// stage widths of each trim store word, stage 0..4, sum, delta
`define ATAP_W0             6
`define ATAP_W1             7
`define ATAP_W2             8
`define ATAP_W3             9
`define ATAP_W4             10
`define ATAP_WS             6
`define ATAP_WD             6
`endif

// *** atap_pkg.sv ***
// types shared by the trim, averaging and pin control block
package atap_pkg;
	// ========================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_CAL  = 3'b100
	} atap_state_t;
	typedef logic [9:0]  atap_store_t;
	typedef logic [15:0] atap_word16_t;
endpackage

// *** atap_top.sv ***
// converter trim, averaging and analog pin control slice with an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "atap_defines.svh"

// Summary of operation
// - setting trim_run starts calibration; it reads one until the sequence ends
// - setting trim_run aborts any conversion in progress
// - trigger select one, register write or stop mode during calibration sets failure
// - failure flag keeps its value through a good run, cleared only by writing one
// - repeat_convert zero runs one conversion or set, one repeats continuously
// - average_enable makes each result come from a set of conversions
// - average_count selects 4, 8, 16 or 32 samples
// - offset is 16-bit two's complement from high and low bytes
// - offset is subtracted once from each averaged result before the result pair
// - corrected result saturates at the limits of the current mode
// - plus gain 1.15 format corrects plus input or whole single-ended conversion
// - minus gain corrects only the minus input, ignored single-ended
// - plus store holds values of 6, 7, 8, 9, 10, 6, 6 bits
// - minus store holds values of the same widths
// - both stores load automatically when calibration ends
// - pin-select low bit n removes port control from channel n pin
// - pin-select mid bit k removes port control from channel k+8 pin
// - selected pin: output tristate, input and pullup off, port reads zero
// - trigger select zero: channel control write starts; one: hardware trigger
module atap_top (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 conv_raw_valid,
	input  wire atap_pkg::atap_word16_t conv_plus_raw,
	input  wire atap_pkg::atap_word16_t conv_minus_raw,
	input  wire logic                 cal_done,
	input  wire atap_pkg::atap_word16_t cal_offset,
	input  wire logic [69:0]          cal_plus_vals,
	input  wire logic [69:0]          cal_minus_vals,
	input  wire logic                 stop_mode,
	input  wire logic                 hw_trigger,
	input  wire logic [15:0]          gpio_drive_req,
	input  wire logic [15:0]          gpio_pullup_req,
	input  wire logic [15:0]          gpio_pin_in,
	output logic                      conv_start,
	output logic                      conv_abort,
	output logic                      cal_start,
	output atap_pkg::atap_word16_t    result_pair,
	output logic                      result_valid,
	output logic                      convert_active,
	output logic [15:0]               gpio_oe_n,
	output logic [15:0]               gpio_pullup_en,
	output logic [15:0]               gpio_ibuf_en,
	output logic [15:0]               gpio_rdata
);
	import atap_pkg::*;

	// ========================================
	// helpers
	function automatic logic [9:0] store_mask(input int i);
		int w;
		case (i)
			0: w = `ATAP_W0;
			1: w = `ATAP_W1;
			2: w = `ATAP_W2;
			3: w = `ATAP_W3;
			4: w = `ATAP_W4;
			5: w = `ATAP_WS;
			default: w = `ATAP_WD;
		endcase
		store_mask = 10'((11'h001 << w) - 11'h001);
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		logic [5:0] idx;
		idx = a[7:2];
		mapped = (idx <= 6'(`ATAP_IDX_PSTORE + `ATAP_STORE_N - 1)) ||
			((idx >= `ATAP_IDX_MSTORE) &&
			 (idx <= 6'(`ATAP_IDX_MSTORE + `ATAP_STORE_N - 1)));
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// ========================================
	// state
	atap_state_t  state_ff;
	logic         aw_have_ff, w_have_ff;
	logic [7:0]   wr_addr_ff;
	logic [31:0]  wr_data_ff;
	logic [3:0]   wr_strb_ff;
	logic         run_ff, fail_ff, repeat_ff, avg_en_ff, hw_sel_ff, diff_ff;
	logic [1:0]   avg_cnt_ff;
	logic [15:0]  ofs_ff, pg_ff, mg_ff, pin_dis_ff;
	logic [7:0]   chan_ff;
	atap_store_t  pstore_ff [`ATAP_STORE_N];
	atap_store_t  mstore_ff [`ATAP_STORE_N];
	logic         hwt_meta_ff, hwt_sync_ff, hwt_prev_ff;
	logic [15:0]  pin_meta_ff, pin_sync_ff;
	logic [24:0]  acc_ff;
	logic [5:0]   cnt_ff;

	// ========================================
	// bus slave
	logic aw_take, w_take, wr_do, ar_take, wr_hit, wr_busy_cal;
	logic nxt_aw_have, nxt_w_have;
	assign aw_take     = s_axi_awvalid && s_axi_awready;
	assign w_take      = s_axi_wvalid && s_axi_wready;
	assign wr_do       = aw_have_ff && w_have_ff && !s_axi_bvalid;
	assign ar_take     = s_axi_arvalid && s_axi_arready;
	assign wr_hit      = wr_do && mapped(wr_addr_ff);
	assign wr_busy_cal = wr_hit && (state_ff == ST_CAL);
	assign nxt_aw_have = wr_do ? 1'b0 : (aw_take ? 1'b1 : aw_have_ff);
	assign nxt_w_have  = wr_do ? 1'b0 : (w_take ? 1'b1 : w_have_ff);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_ff    <= 1'b0;
			w_have_ff     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			wr_addr_ff    <= 8'h00;
			wr_data_ff    <= 32'h0000_0000;
			wr_strb_ff    <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ATAP_RESP_OK;
		end else begin
			aw_have_ff    <= nxt_aw_have;
			w_have_ff     <= nxt_w_have;
			s_axi_awready <= !nxt_aw_have;
			s_axi_wready  <= !nxt_w_have;
			if (aw_take) begin
				wr_addr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				wr_data_ff <= s_axi_wdata;
				wr_strb_ff <= s_axi_wstrb;
			end
			if (wr_do) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(wr_addr_ff) ? `ATAP_RESP_OK : `ATAP_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			`ATAP_OFS_CTRL3:   rd_word[7:0] = {run_ff, fail_ff, 2'b00, repeat_ff,
				avg_en_ff, avg_cnt_ff};
			`ATAP_OFS_OFS_HI:  rd_word[7:0] = ofs_ff[15:8];
			`ATAP_OFS_OFS_LO:  rd_word[7:0] = ofs_ff[7:0];
			`ATAP_OFS_PG_HI:   rd_word[7:0] = pg_ff[15:8];
			`ATAP_OFS_PG_LO:   rd_word[7:0] = pg_ff[7:0];
			`ATAP_OFS_MG_HI:   rd_word[7:0] = mg_ff[15:8];
			`ATAP_OFS_MG_LO:   rd_word[7:0] = mg_ff[7:0];
			`ATAP_OFS_PIN_LO:  rd_word[7:0] = pin_dis_ff[7:0];
			`ATAP_OFS_PIN_MID: rd_word[7:0] = pin_dis_ff[15:8];
			`ATAP_OFS_CTRL2: begin
				rd_word[`ATAP_B_HWTRG] = hw_sel_ff;
				rd_word[`ATAP_B_DIFF]  = diff_ff;
			end
			`ATAP_OFS_CHAN1:   rd_word[7:0] = chan_ff;
			`ATAP_OFS_RESULT: begin
				rd_word[15:0]        = result_pair;
				rd_word[`ATAP_B_BUSY] = convert_active;
			end
			default: begin
				for (int i = 0; i < `ATAP_STORE_N; i++) begin
					if (s_axi_araddr[7:2] == 6'(`ATAP_IDX_PSTORE + i))
						rd_word[9:0] = pstore_ff[i];
					if (s_axi_araddr[7:2] == 6'(`ATAP_IDX_MSTORE + i))
						rd_word[9:0] = mstore_ff[i];
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `ATAP_RESP_OK;
		end else begin
			if (ar_take) begin
				s_axi_rvalid  <= 1'b1;
				s_axi_arready <= 1'b0;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= mapped(s_axi_araddr) ? `ATAP_RESP_OK : `ATAP_RESP_ERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ========================================
	// configuration registers
	logic wr_lane0;
	assign wr_lane0 = wr_hit && wr_strb_ff[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			repeat_ff  <= 1'b0;
			avg_en_ff  <= 1'b0;
			avg_cnt_ff <= 2'b00;
			hw_sel_ff  <= 1'b0;
			diff_ff    <= 1'b0;
			chan_ff    <= `ATAP_RST_BYTE;
			pg_ff      <= `ATAP_RST_GAIN;
			mg_ff      <= `ATAP_RST_GAIN;
			pin_dis_ff <= 16'h0000;
		end else if (wr_lane0) begin
			case (wr_addr_ff)
				`ATAP_OFS_CTRL3: begin
					repeat_ff  <= wr_data_ff[`ATAP_B_REPEAT];
					avg_en_ff  <= wr_data_ff[`ATAP_B_AVGEN];
					avg_cnt_ff <= wr_data_ff[1:0];
				end
				`ATAP_OFS_CTRL2: begin
					hw_sel_ff <= wr_data_ff[`ATAP_B_HWTRG];
					diff_ff   <= wr_data_ff[`ATAP_B_DIFF];
				end
				`ATAP_OFS_CHAN1:   chan_ff          <= wr_data_ff[7:0];
				`ATAP_OFS_PG_HI:   pg_ff[15:8]      <= wr_data_ff[7:0];
				`ATAP_OFS_PG_LO:   pg_ff[7:0]       <= wr_data_ff[7:0];
				`ATAP_OFS_MG_HI:   mg_ff[15:8]      <= wr_data_ff[7:0];
				`ATAP_OFS_MG_LO:   mg_ff[7:0]       <= wr_data_ff[7:0];
				`ATAP_OFS_PIN_LO:  pin_dis_ff[7:0]  <= wr_data_ff[7:0];
				`ATAP_OFS_PIN_MID: pin_dis_ff[15:8] <= wr_data_ff[7:0];
				default: ;
			endcase
		end
	end

	// offset is loaded by software or by a finished calibration
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ofs_ff <= `ATAP_RST_OFS;
		end else if (state_ff == ST_CAL && cal_done) begin
			ofs_ff <= cal_offset;
		end else if (wr_lane0 && wr_addr_ff == `ATAP_OFS_OFS_HI) begin
			ofs_ff[15:8] <= wr_data_ff[7:0];
		end else if (wr_lane0 && wr_addr_ff == `ATAP_OFS_OFS_LO) begin
			ofs_ff[7:0] <= wr_data_ff[7:0];
		end
	end

	// ========================================
	// trim stores, widths clipped per stage
	generate
		for (genvar g = 0; g < `ATAP_STORE_N; g++) begin : g_store
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pstore_ff[g] <= 10'h000;
					mstore_ff[g] <= 10'h000;
				end else if (state_ff == ST_CAL && cal_done) begin
					pstore_ff[g] <= cal_plus_vals[g*10 +: 10] & store_mask(g);
					mstore_ff[g] <= cal_minus_vals[g*10 +: 10] & store_mask(g);
				end else if (wr_hit && wr_addr_ff[7:2] == 6'(`ATAP_IDX_PSTORE + g)) begin
					pstore_ff[g] <= 10'(merge16({6'h00, pstore_ff[g]}, wr_data_ff,
						wr_strb_ff)) & store_mask(g);
				end else if (wr_hit && wr_addr_ff[7:2] == 6'(`ATAP_IDX_MSTORE + g)) begin
					mstore_ff[g] <= 10'(merge16({6'h00, mstore_ff[g]}, wr_data_ff,
						wr_strb_ff)) & store_mask(g);
				end
			end
		end
	endgenerate

	// ========================================
	// synchronisers for pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hwt_meta_ff <= 1'b0;
			hwt_sync_ff <= 1'b0;
			hwt_prev_ff <= 1'b0;
			pin_meta_ff <= 16'h0000;
			pin_sync_ff <= 16'h0000;
		end else begin
			hwt_meta_ff <= hw_trigger;
			hwt_sync_ff <= hwt_meta_ff;
			hwt_prev_ff <= hwt_sync_ff;
			pin_meta_ff <= gpio_pin_in;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	// ========================================
	// correction datapath
	logic        cal_req, conv_req, set_done;
	logic [31:0] pprod, mprod;
	logic [19:0] sample;
	logic [24:0] acc_sum, avg;
	logic [20:0] corr;
	logic [15:0] sat;
	logic [5:0]  target;
	logic [2:0]  shift;

	assign cal_req  = wr_lane0 && wr_addr_ff == `ATAP_OFS_CTRL3 &&
		wr_data_ff[`ATAP_B_RUN] && state_ff != ST_CAL;
	assign conv_req = !cal_req && (hw_sel_ff ? (hwt_sync_ff && !hwt_prev_ff) :
		(wr_lane0 && wr_addr_ff == `ATAP_OFS_CHAN1));
	assign pprod    = conv_plus_raw * pg_ff;
	assign mprod    = conv_minus_raw * mg_ff;
	// gains are 1.15, so the product's upper 17 bits are the corrected sample
	assign sample   = {3'b000, pprod[31:15]} -
		(diff_ff ? {3'b000, mprod[31:15]} : 20'h00000);
	assign target   = avg_en_ff ? 6'(6'h04 << avg_cnt_ff) : 6'h01;
	assign shift    = avg_en_ff ? ({1'b0, avg_cnt_ff} + 3'h2) : 3'h0;
	assign acc_sum  = acc_ff + {{5{sample[19]}}, sample};
	assign avg      = 25'($signed(acc_sum) >>> shift);
	assign corr     = {avg[19], avg[19:0]} - {{5{ofs_ff[15]}}, ofs_ff};
	assign set_done = conv_raw_valid && (cnt_ff + 6'h01 == target);

	// limits follow the mode: signed 16 bit when differential, else unsigned
	always_comb begin
		sat = corr[15:0];
		if (diff_ff) begin
			if ($signed(corr) > $signed(21'h007FFF))
				sat = 16'h7FFF;
			else if ($signed(corr) < $signed(21'h1F8000))
				sat = 16'h8000;
		end else begin
			if (corr[20])
				sat = 16'h0000;
			else if (corr[19:16] != 4'h0)
				sat = 16'hFFFF;
		end
	end

	// ========================================
	// sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff       <= ST_IDLE;
			conv_start     <= 1'b0;
			conv_abort     <= 1'b0;
			cal_start      <= 1'b0;
			result_valid   <= 1'b0;
			result_pair    <= 16'h0000;
			acc_ff         <= 25'h0000000;
			cnt_ff         <= 6'h00;
			convert_active <= 1'b0;
		end else begin
			conv_start   <= 1'b0;
			conv_abort   <= 1'b0;
			cal_start    <= 1'b0;
			result_valid <= 1'b0;
			unique case (state_ff)
				ST_IDLE, ST_CONV: begin
					if (cal_req) begin
						state_ff       <= ST_CAL;
						cal_start      <= 1'b1;
						conv_abort     <= (state_ff == ST_CONV);
						convert_active <= 1'b0;
					end else if (state_ff == ST_IDLE || conv_req) begin
						if (conv_req) begin
							state_ff       <= ST_CONV;
							conv_start     <= 1'b1;
							convert_active <= 1'b1;
							acc_ff         <= 25'h0000000;
							cnt_ff         <= 6'h00;
						end
					end else if (conv_raw_valid) begin
						conv_start <= 1'b1;
						acc_ff     <= acc_sum;
						cnt_ff     <= cnt_ff + 6'h01;
						if (set_done) begin
							result_pair  <= sat;
							result_valid <= 1'b1;
							acc_ff       <= 25'h0000000;
							cnt_ff       <= 6'h00;
							if (!repeat_ff) begin
								state_ff       <= ST_IDLE;
								conv_start     <= 1'b0;
								convert_active <= 1'b0;
							end
						end
					end
				end
				ST_CAL: begin
					if (cal_done) begin
						state_ff <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// trim_run mirrors the sequence; failure flag is sticky, set beats clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_ff  <= 1'b0;
			fail_ff <= 1'b0;
		end else begin
			if (cal_req)
				run_ff <= 1'b1;
			else if (state_ff == ST_CAL && cal_done)
				run_ff <= 1'b0;
			if (state_ff == ST_CAL && (hw_sel_ff || wr_busy_cal || stop_mode))
				fail_ff <= 1'b1;
			else if (wr_lane0 && wr_addr_ff == `ATAP_OFS_CTRL3 &&
				wr_data_ff[`ATAP_B_FAIL])
				fail_ff <= 1'b0;
		end
	end

	// ========================================
	// pin control
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gpio_oe_n      <= 16'hFFFF;
			gpio_pullup_en <= 16'h0000;
			gpio_ibuf_en   <= 16'h0000;
			gpio_rdata     <= 16'h0000;
		end else begin
			gpio_oe_n      <= ~(gpio_drive_req & ~pin_dis_ff);
			gpio_pullup_en <= gpio_pullup_req & ~pin_dis_ff;
			gpio_ibuf_en   <= ~pin_dis_ff;
			gpio_rdata     <= pin_sync_ff & ~pin_dis_ff;
		end
	end
endmodule // atap_top

// *** atap_checker.sv ***
// assertion checker for the trim, averaging and pin control block
`timescale 1ns/1ps
module atap_checker (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        conv_raw_valid,
	input wire logic        conv_start,
	input wire logic        conv_abort,
	input wire logic        cal_start,
	input wire logic        result_valid,
	input wire logic        convert_active,
	input wire logic [15:0] gpio_oe_n,
	input wire logic [15:0] gpio_pullup_en,
	input wire logic [15:0] gpio_ibuf_en
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ========================================
	// register bus
	sequence both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence resp_after_apply;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	write_answer_a:
		assert property (both_taken |=> resp_after_apply) else $error("write response timing");
	write_release_a:
		assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
	read_answer_a:
		assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer timing");
	read_release_a:
		assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
	// ========================================
	// converter link
	sequence sample_taken;
		conv_raw_valid && convert_active;
	endsequence
	abort_with_cal_a:
		assert property (conv_abort |-> cal_start) else $error("abort without calibration");
	sample_answer_a:
		assert property (sample_taken |=> conv_start || result_valid || cal_start)
		else $error("sample left unanswered");
	single_stop_a:
		assert property (result_valid && !conv_start |-> !convert_active)
		else $error("sequence kept running");
	result_cause_a:
		assert property (result_valid |-> $past(conv_raw_valid)) else $error("result without sample");
	// ========================================
	// pin control: a disabled input buffer marks an analog pin
	pin_no_drive_a:
		assert property ((~gpio_oe_n & ~gpio_ibuf_en) == 16'h0000) else $error("analog pin driven");
	pin_no_pull_a:
		assert property ((gpio_pullup_en & ~gpio_ibuf_en) == 16'h0000) else $error("analog pin pulled");
endmodule // atap_checker

bind atap_top atap_checker u_atap_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .conv_raw_valid, .conv_start, .conv_abort, .cal_start,
	.result_valid, .convert_active, .gpio_oe_n, .gpio_pullup_en, .gpio_ibuf_en);

// *** tb.sv ***
// self-checking testbench for the trim, averaging and pin control block
`timescale 1ns/1ps
`include "atap_defines.svh"
`define CHK(nm, e, g) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("MISMATCH %s exp %h got %h", nm, e, g); \
	end \
end
module tb;
	import atap_pkg::*;
	typedef struct {logic [7:0] a; logic [15:0] r0, w, e; logic [1:0] s;} atap_row_t;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic conv_raw_valid, cal_done, stop_mode, hw_trigger, conv_start, conv_abort, cal_start;
	logic result_valid, convert_active;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rq;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	atap_word16_t conv_plus_raw, conv_minus_raw, cal_offset, result_pair;
	logic [69:0] cal_plus_vals, cal_minus_vals;
	logic [15:0] gpio_drive_req, gpio_pullup_req, gpio_pin_in;
	logic [15:0] gpio_oe_n, gpio_pullup_en, gpio_ibuf_en, gpio_rdata;
	int n_fail, checks_done, n_abort, n_cal;
	// address in the high byte, value in the low byte
	logic [15:0] restore [8] = '{16'h0C80, 16'h1480, 16'h1000, 16'h1800, 16'h0400, 16'h0810,
		16'h1C00, 16'h2000};
	atap_row_t rows [16] = '{
		'{8'h04, 16'h0, 16'hFF5A, 16'h5A, 2'h0}, '{8'h08, 16'h0, 16'h1A5, 16'hA5, 2'h0},
		'{8'h0C, 16'h80, 16'h12, 16'h12, 2'h0}, '{8'h10, 16'h0, 16'h34, 16'h34, 2'h0},
		'{8'h14, 16'h80, 16'h56, 16'h56, 2'h0}, '{8'h18, 16'h0, 16'h78, 16'h78, 2'h0},
		'{8'h1C, 16'h0, 16'h5A, 16'h5A, 2'h0}, '{8'h20, 16'h0, 16'hC3, 16'hC3, 2'h0},
		'{8'h30, 16'h0, 16'hFFFF, 16'h3F, 2'h0}, '{8'h34, 16'h0, 16'hFFFF, 16'h7F, 2'h0},
		'{8'h38, 16'h0, 16'hFFFF, 16'hFF, 2'h0}, '{8'h3C, 16'h0, 16'hFFFF, 16'h1FF, 2'h0},
		'{8'h40, 16'h0, 16'hFFFF, 16'h3FF, 2'h0}, '{8'h48, 16'h0, 16'hFFFF, 16'h3F, 2'h0},
		'{8'h5C, 16'h0, 16'hFFFF, 16'h1FF, 2'h0}, '{8'h7C, 16'h0, 16'hFFFF, 16'h0, 2'h2}};

	atap_top u_atap_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .conv_raw_valid, .conv_plus_raw, .conv_minus_raw, .cal_done,
		.cal_offset, .cal_plus_vals, .cal_minus_vals, .stop_mode, .hw_trigger, .gpio_drive_req,
		.gpio_pullup_req, .gpio_pin_in, .conv_start, .conv_abort, .cal_start, .result_pair,
		.result_valid, .convert_active, .gpio_oe_n, .gpio_pullup_en, .gpio_ibuf_en, .gpio_rdata);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (conv_abort === 1'b1) n_abort++;
		if (cal_start === 1'b1) n_cal++;
	end
	// ========================================
	// bus and converter tasks
	task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
		end
		// ready lines stay high, so the answer is taken at the edge it is seen
		for (t = 0; t < 40; t++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (w ? s_axi_bvalid : s_axi_rvalid) begin
				rr = w ? s_axi_bresp : s_axi_rresp;
				rq = s_axi_rdata;
				break;
			end
		end
		if (t == 40) `CHK("bus answer", 1'b1, 1'b0)
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] s);
		axi(1'b0, a, 32'h0);
		`CHK($sformatf("reg %h", a), e, rq)
		`CHK($sformatf("resp %h", a), s, rr)
	endtask
	task automatic conv(input logic st, input int n, input logic [15:0] p0, p1, m, e);
		int t;
		if (st) wr(`ATAP_OFS_CHAN1, 32'h0);
		for (int i = 0; i < n; i++) begin
			t = 0;
			while (conv_start !== 1'b1 && t < 30) begin
				@(posedge aclk);
				t++;
			end
			`CHK("conv start", 1'b1, conv_start)
			conv_raw_valid <= 1'b1;
			conv_plus_raw <= i[0] ? p1 : p0;
			conv_minus_raw <= m;
			@(posedge aclk);
			conv_raw_valid <= 1'b0;
		end
		// the result pulse stands only in the cycle after the last sample
		@(posedge aclk);
		`CHK("result valid", 1'b1, result_valid)
		`CHK("result", e, result_pair)
	endtask
	task automatic cal_run(input int cause, input logic fail);
		wr(`ATAP_OFS_CTRL3, 32'h80);
		// trigger select one flags the run from its first cycle
		rdc(`ATAP_OFS_CTRL3, {1'b1, fail && cause == 0, 6'h0}, 2'h0);
		if (cause == 1) begin
			stop_mode <= 1'b1;
			@(posedge aclk);
			stop_mode <= 1'b0;
		end
		if (cause == 2) wr(`ATAP_OFS_OFS_LO, 32'h1);
		cal_done <= 1'b1;
		@(posedge aclk);
		cal_done <= 1'b0;
		repeat (2) @(posedge aclk);
		rdc(`ATAP_OFS_CTRL3, {fail, 6'h0}, 2'h0);
		$display("test calibration cause %0d done", cause);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		`CHK("watchdog", 1'b0, 1'b1)
		wrap_up;
	end
	// ========================================
	// main sequence
	initial begin
		aresetn = 1'b0;
		s_axi_wstrb = 4'hF;
		cal_offset = 16'h0020;
		{s_axi_bready, s_axi_rready} = 2'b11;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, conv_raw_valid, cal_done, stop_mode} = '0;
		{hw_trigger, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{conv_plus_raw, conv_minus_raw, cal_plus_vals, cal_minus_vals} = '0;
		{gpio_drive_req, gpio_pullup_req, gpio_pin_in} = '1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdc(`ATAP_OFS_CTRL3, 32'h0, 2'h0);
		foreach (rows[i]) begin
			rdc(rows[i].a, rows[i].r0, rows[i].s);
			wr(rows[i].a, rows[i].w);
			`CHK("write resp", rows[i].s, rr)
			rdc(rows[i].a, rows[i].e, rows[i].s);
		end
		$display("test register table done");
		// pin sync takes two edges, the output registers one more
		repeat (4) @(posedge aclk);
		`CHK("oe_n", 16'hC35A, gpio_oe_n)
		`CHK("pullup", 16'h3CA5, gpio_pullup_en)
		`CHK("ibuf", 16'h3CA5, gpio_ibuf_en)
		`CHK("port read", 16'h3CA5, gpio_rdata)
		$display("test pins done");
		foreach (restore[i]) wr(restore[i][15:8], {24'h0, restore[i][7:0]});
		wr(`ATAP_OFS_CTRL3, 32'h3);
		conv(1'b1, 1, 16'h1234, 16'h1234, 16'h0, 16'h1224);
		conv(1'b1, 1, 16'h0008, 16'h0008, 16'h0, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			wr(`ATAP_OFS_CTRL3, 32'h4 | c);
			conv(1'b1, 4 << c, 16'h0100, 16'h0300, 16'h0, 16'h01F0);
		end
		wr(`ATAP_OFS_CTRL3, 32'h0);
		wr(`ATAP_OFS_CTRL2, 32'h1);
		wr(`ATAP_OFS_MG_HI, 32'h40);
		conv(1'b1, 1, 16'h1000, 16'h1000, 16'h0800, 16'h0BF0);
		conv(1'b1, 1, 16'h0000, 16'h0000, 16'hFFFF, 16'h8000);
		wr(`ATAP_OFS_CTRL2, 32'h0);
		wr(`ATAP_OFS_PG_HI, 32'h40);
		conv(1'b1, 1, 16'h2000, 16'h2000, 16'hFFFF, 16'h0FF0);
		$display("test conversions done");
		wr(`ATAP_OFS_CTRL2, 32'h40);
		hw_trigger <= 1'b1;
		conv(1'b0, 1, 16'h0400, 16'h0400, 16'h0, 16'h01F0);
		hw_trigger <= 1'b0;
		rdc(`ATAP_OFS_RESULT, 32'h0000_01F0, 2'h0);
		cal_run(0, 1'b1);
		wr(`ATAP_OFS_CTRL2, 32'h0);
		wr(`ATAP_OFS_CTRL3, 32'h0);
		rdc(`ATAP_OFS_CTRL3, 32'h40, 2'h0);
		wr(`ATAP_OFS_CTRL3, 32'h40);
		rdc(`ATAP_OFS_CTRL3, 32'h0, 2'h0);
		cal_offset <= 16'h0033;
		cal_plus_vals <= 70'h15;
		cal_minus_vals <= 70'h2AB << 40;
		wr(`ATAP_OFS_CTRL3, 32'h8);
		conv(1'b1, 1, 16'h0400, 16'h0400, 16'h0, 16'h01E0);
		conv(1'b0, 1, 16'h0600, 16'h0600, 16'h0, 16'h02E0);
		rdc(`ATAP_OFS_RESULT, 32'h0001_02E0, 2'h0);
		cal_run(0, 1'b0);
		`CHK("abort count", 1, n_abort)
		rdc(`ATAP_OFS_OFS_LO, 32'h33, 2'h0);
		rdc(8'h30, 32'h15, 2'h0);
		rdc(8'h60, 32'h2AB, 2'h0);
		wr(`ATAP_OFS_PG_HI, 32'h80);
		wr(`ATAP_OFS_MG_HI, 32'h80);
		rdc(`ATAP_OFS_MG_HI, 32'h80, 2'h0);
		cal_run(1, 1'b1);
		wr(`ATAP_OFS_CTRL3, 32'h40);
		cal_run(2, 1'b1);
		`CHK("cal count", 4, n_cal)
		wrap_up;
	end
endmodule // tb
